//--- hdl/rsc_core.sv
// Purpose: Square wave, battery flag, century, output pin, osc fail, calibration
// Assumes: Host register writes arrive as one-cycle strobes with data
// Notes: Oscillator is modelled by a prescaler tick from core_clk
`timescale 1ns/1ns
`default_nettype none
`include "rsc_params.svh"
// Overview of operation
// RULE1 - Four-bit code picks square-wave frequency
// RULE2 - Square wave only while enable bit set
// RULE3 - Supply below switchover disables square wave
// RULE4 - Battery check at power-up and daily
// RULE5 - Failed check sets battery-low flag
// RULE6 - Battery-low flag stays until check passes
// RULE7 - No battery checks in back-up mode
// RULE8 - Century bits count up at year rollover
// RULE9 - Leap year rule with 100/400 exceptions
// RULE10 - Output pin follows level bit when idle
// RULE11 - Oscillator stop sets fail flag
// RULE12 - First power and halt bit set flag
// RULE13 - Fail flag holds until written zero
// RULE14 - Software waits 4 s before clearing; the host model clears after only 20 or 2 core cycles
// RULE15 - Software restarts oscillator via halt bit
// RULE16 - Flag and enable drive interrupt pin
// RULE17 - Initial power-up loads default values
// RULE18 - Later power-up clears some bits
// RULE19 - Lock bit copies factory calibration, read-only
// RULE20 - Unlocked calibration register is read/write
// RULE21 - Factory copy completes after 8 ms
// RULE22 - Flags read leaves fail flag set
// RULE23 - Frequencies from binary prescaler chain
module rsc_core #(
  parameter int OSC_DIV = `RSC_OSC_DIV,
  parameter longint BATT_TICKS = `RSC_BATT_TICKS,
  parameter int CAL_CYCLES = `RSC_CAL_CYCLES,
  parameter logic [7:0] FACTORY_CAL = 8'h00 // Arbitrary stand-in trim value
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic initial_power, // Level: first power ever (no prior backup)
  input wire logic main_power_ok, // Level: supply above switchover
  input wire logic osc_stopped, // Level: oscillator halted by any cause
  input wire logic batt_below_thr, // Level: comparator result
  input wire logic ctrl_we, // Strobe: write of control bits
  input wire rsc_pkg::rsc_ctrl_t ctrl_wdata,
  input wire logic halt_we, // Strobe: write of halt bit
  input wire logic halt_wdata,
  input wire logic fail_clr, // Strobe: host writes fail flag to 0
  input wire logic flags_rd, // Strobe: flags register read
  input wire logic cal_we, // Strobe: calibration register write
  input wire logic [7:0] cal_wdata,
  input wire logic year_rollover, // Strobe: year goes 99 to 00
  input wire logic [6:0] year_units, // Binary year 0..99 within century
  output logic sq_wave_pin,
  output logic mp_pin_oe, // Open drain: high while pulling low
  output logic batt_low_flag,
  output logic osc_fail_flag,
  output logic century_bit_lo,
  output logic century_bit_hi,
  output logic leap_year,
  output logic [7:0] cal_reg,
  output logic cal_busy,
  output rsc_pkg::rsc_ctrl_t ctrl_q,
  output logic osc_halt_bit,
  output logic freq_test_en,
  output logic countdown_en,
  output logic stamp_hold_bit
);

  // Oscillator tick prescaler
  logic [15:0] osc_cnt;
  logic osc_tick;
  // Binary prescaler chain, bit 0 toggles on every oscillator tick (16.384 kHz square)
  logic [14:0] chain;
  // Battery interval counter
  logic [41:0] batt_cnt;
  rsc_pkg::rsc_batt_state_t batt_st;
  logic [23:0] cal_cnt;
  logic cal_lock_q;
  logic started;

  // Selects a prescaler tap for a frequency code
  function automatic logic sq_tap(input logic [3:0] sel, input logic tick_lvl,
                                  input logic [14:0] c);
    if (sel == 4'h0) begin
      sq_tap = 1'b0;
    end else if (sel == 4'h1) begin
      sq_tap = tick_lvl;
    end else begin
      sq_tap = c[sel - 4'h1];
    end
  endfunction

  // Leap test given century code and year within century
  function automatic logic leap_of(input logic [1:0] cen, input logic [6:0] yr);
    if (yr == 7'h00) begin
      leap_of = (cen == 2'h0);
    end else begin
      leap_of = (yr[1:0] == 2'h0);
    end
  endfunction

  // Oscillator tick generation
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      osc_cnt <= 16'h0000;
      osc_tick <= 1'b0;
    end else if (osc_cnt == 16'(OSC_DIV - 1)) begin
      osc_cnt <= 16'h0000;
      osc_tick <= !osc_stopped && !osc_halt_bit;
    end else begin
      osc_cnt <= osc_cnt + 16'h0001;
      osc_tick <= 1'b0;
    end
  end

  // Divider chain runs on each oscillator tick
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      chain <= 15'h0000;
    end else if (osc_tick) begin
      chain <= chain + 15'h0001; // RULE23
    end
  end

  // Square wave output select and gating
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      sq_wave_pin <= 1'b0;
    end else if (ctrl_q.sq_pin_en && main_power_ok) begin // RULE2 RULE3
      sq_wave_pin <= sq_tap(ctrl_q.sq_freq_sel, osc_tick, chain); // RULE1
    end else begin
      sq_wave_pin <= 1'b0;
    end
  end

  // Power-up marker and the bits that every power-up reloads
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      started <= 1'b0;
      freq_test_en <= 1'b0; // RULE18
      countdown_en <= 1'b0; // RULE18
      stamp_hold_bit <= 1'b1; // RULE18
    end else begin
      started <= 1'b1;
    end
  end

  // Battery-backed control bits, kept across a later power-up except dog_active, which is cleared
  always_ff @(posedge core_clk) begin
    if (!started) begin
      ctrl_q.dog_active <= 1'b0; // RULE18
      if (initial_power) begin
          ctrl_q.sq_freq_sel <= `RSC_RST_FREQ_SEL; // RULE17
          ctrl_q.sq_pin_en <= `RSC_RST_SQ_EN;
          ctrl_q.out_level <= 1'b1;
          ctrl_q.osc_fail_irq_en <= 1'b0;
          ctrl_q.alarm1_irq_en <= 1'b0;
          ctrl_q.cal_lock <= 1'b0;
          osc_halt_bit <= 1'b0;
        end
    end else begin
      if (ctrl_we) begin
        ctrl_q <= ctrl_wdata;
      end
      if (halt_we) begin
        osc_halt_bit <= halt_wdata;
      end
    end
  end

  // Oscillator fail flag, battery backed so a stop during power-down is kept
  always_ff @(posedge core_clk) begin
    if (osc_stopped || (halt_we && halt_wdata) || (!started && initial_power)) begin
      osc_fail_flag <= 1'b1; // RULE11 RULE12
    end else if (fail_clr) begin
      osc_fail_flag <= 1'b0; // RULE13 RULE22
    end
  end

  // Multi-purpose open-drain pin
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      mp_pin_oe <= 1'b0;
    end else if (ctrl_q.osc_fail_irq_en) begin
      mp_pin_oe <= osc_fail_flag; // RULE16
    end else if (!ctrl_q.alarm1_irq_en && !ctrl_q.dog_active) begin
      mp_pin_oe <= !ctrl_q.out_level; // RULE10
    end else begin
      mp_pin_oe <= 1'b0;
    end
  end

  // Battery check scheduler
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      batt_st <= rsc_pkg::RSC_CHECK; // RULE4
      batt_cnt <= 42'h0;
      batt_low_flag <= 1'b0;
    end else begin
      unique case (batt_st)
        rsc_pkg::RSC_IDLE: begin
          if (main_power_ok) begin
            batt_st <= rsc_pkg::RSC_CHECK;
          end
        end
        rsc_pkg::RSC_CHECK: begin
          if (main_power_ok) begin // RULE7
            batt_low_flag <= batt_below_thr; // RULE5 RULE6
            batt_cnt <= 42'h0;
            batt_st <= rsc_pkg::RSC_WAIT;
          end else begin
            batt_st <= rsc_pkg::RSC_IDLE;
          end
        end
        rsc_pkg::RSC_WAIT: begin
          if (!main_power_ok) begin
            batt_st <= rsc_pkg::RSC_IDLE; // RULE7
          end else if (osc_tick) begin
            if (batt_cnt == 42'(BATT_TICKS - 1)) begin
              batt_st <= rsc_pkg::RSC_CHECK; // RULE4
            end else begin
              batt_cnt <= batt_cnt + 42'h1;
            end
          end
        end
        default: batt_st <= rsc_pkg::RSC_IDLE;
      endcase
    end
  end

  // Century counter, battery backed, and leap flag
  always_ff @(posedge core_clk) begin
    if (!started && initial_power) begin
      {century_bit_hi, century_bit_lo} <= 2'h0; // RULE17
    end else if (year_rollover) begin
      {century_bit_hi, century_bit_lo} <= {century_bit_hi, century_bit_lo} + 2'h1; // RULE8
    end
    leap_year <= leap_of({century_bit_hi, century_bit_lo}, year_units); // RULE9
  end

  // Factory copy timer, restarted by a rising lock bit
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      cal_busy <= 1'b0;
      cal_cnt <= 24'h0;
      cal_lock_q <= 1'b0;
    end else begin
      cal_lock_q <= ctrl_q.cal_lock;
      if (ctrl_q.cal_lock && !cal_lock_q) begin
        cal_busy <= 1'b1;
        cal_cnt <= 24'h0;
      end else if (cal_busy) begin
        if (!ctrl_q.cal_lock) begin
          cal_busy <= 1'b0;
        end else if (cal_cnt == 24'(CAL_CYCLES - 1)) begin
          cal_busy <= 1'b0; // RULE21
        end else begin
          cal_cnt <= cal_cnt + 24'h1;
        end
      end
    end
  end

  // Calibration value, battery backed: factory copy or host write
  always_ff @(posedge core_clk) begin
    if (!started && initial_power) begin
      cal_reg <= 8'h00; // RULE17
    end else if (cal_busy && ctrl_q.cal_lock && cal_cnt == 24'(CAL_CYCLES - 1)) begin
      cal_reg <= FACTORY_CAL; // RULE19
    end else if (cal_we && !ctrl_q.cal_lock && !cal_busy) begin
      cal_reg <= cal_wdata; // RULE20
    end
  end

  // Assertions
  property p_sq_off;
    @(posedge core_clk) disable iff (!rst_n)
      (!ctrl_q.sq_pin_en || !main_power_ok) |=> !sq_wave_pin;
  endproperty
  a_sq_off: assert property (p_sq_off) else $error("square wave not off"); // RULE2

  property p_fail_hold;
    @(posedge core_clk) disable iff (!rst_n)
      (osc_fail_flag && !fail_clr) |=> osc_fail_flag;
  endproperty
  a_fail_hold: assert property (p_fail_hold) else $error("fail flag dropped"); // RULE13

  property p_fail_set;
    @(posedge core_clk) disable iff (!rst_n) osc_stopped |=> osc_fail_flag;
  endproperty
  a_fail_set: assert property (p_fail_set) else $error("fail flag not set"); // RULE11

  property p_irq;
    @(posedge core_clk) disable iff (!rst_n)
      (ctrl_q.osc_fail_irq_en && osc_fail_flag) |=> mp_pin_oe;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt pin not driven"); // RULE16

  property p_out_level;
    @(posedge core_clk) disable iff (!rst_n)
      (!ctrl_q.osc_fail_irq_en && !ctrl_q.alarm1_irq_en && !ctrl_q.dog_active)
      |=> (mp_pin_oe == !$past(ctrl_q.out_level));
  endproperty
  a_out_level: assert property (p_out_level) else $error("pin ignores level"); // RULE10

  property p_cal_ro;
    @(posedge core_clk) disable iff (!rst_n)
      (ctrl_q.cal_lock && cal_lock_q && !cal_busy) |=> $stable(cal_reg);
  endproperty
  a_cal_ro: assert property (p_cal_ro) else $error("locked register changed"); // RULE19

  property p_cal_rw;
    @(posedge core_clk) disable iff (!rst_n)
      (cal_we && !ctrl_q.cal_lock && !cal_busy) |=> (cal_reg == $past(cal_wdata));
  endproperty
  a_cal_rw: assert property (p_cal_rw) else $error("write lost"); // RULE20

  property p_century;
    @(posedge core_clk) disable iff (!rst_n)
      year_rollover |=> ({century_bit_hi, century_bit_lo} ==
                         $past({century_bit_hi, century_bit_lo}) + 2'h1);
  endproperty
  a_century: assert property (p_century) else $error("century not counted"); // RULE8

  property p_no_check;
    @(posedge core_clk) disable iff (!rst_n)
      !main_power_ok |=> $stable(batt_low_flag);
  endproperty
  a_no_check: assert property (p_no_check) else $error("check on backup"); // RULE7

  property p_read_keeps;
    @(posedge core_clk) disable iff (!rst_n)
      (flags_rd && osc_fail_flag && !fail_clr) |=> osc_fail_flag;
  endproperty
  a_read_keeps: assert property (p_read_keeps) else $error("read cleared fail flag"); // RULE22

endmodule
`default_nettype wire

//--- hdl/rsc_params.svh
// Purpose: Constants for the status and output control block
// Assumes: 125 MHz core clock
// Notes: Timing counts derived from printed times
`ifndef RSC_PARAMS_SVH
`define RSC_PARAMS_SVH
// Core clock period in ns
`define RSC_CLK_NS 8
// Oscillator period in core cycles (about 32.768 kHz)
`define RSC_OSC_DIV 3815
// Battery interval in hours and in oscillator ticks
`define RSC_BATT_HOURS 24
`define RSC_BATT_TICKS (64'(`RSC_BATT_HOURS) * 3600 * 32768)
// Calibration copy time in ms and in core cycles
`define RSC_CAL_MS 8
`define RSC_CAL_CYCLES ((`RSC_CAL_MS * 1000000) / `RSC_CLK_NS)
// Power-on reset values
`define RSC_RST_FREQ_SEL 4'h1
`define RSC_RST_SQ_EN 1'b1
`define RSC_RST_CLK_SEL 2'h3
`endif

//--- hdl/rsc_pkg.sv
// Purpose: Types for the status and output control block
// Assumes: Nothing
// Notes: Types only
package rsc_pkg;
  // Host-written control bits
  typedef struct packed {
    logic [3:0] sq_freq_sel;
    logic sq_pin_en;
    logic out_level;
    logic osc_fail_irq_en;
    logic alarm1_irq_en;
    logic dog_active;
    logic cal_lock;
  } rsc_ctrl_t;
  // Battery check states
  typedef enum logic [2:0] {
    RSC_IDLE = 3'b001,
    RSC_WAIT = 3'b010,
    RSC_CHECK = 3'b100
  } rsc_batt_state_t;
endpackage

//--- sim/rsc_host.sv
// Purpose: Host-side model that issues register strobes to the block
// Assumes: Strobes change at the falling edge and last one cycle
// Notes: Called by the bench through hierarchical task calls
`timescale 1ns/1ns
`default_nettype none
module rsc_host (
  input wire logic core_clk,
  output logic ctrl_we,
  output rsc_pkg::rsc_ctrl_t ctrl_wdata,
  output logic halt_we,
  output logic halt_wdata,
  output logic fail_clr,
  output logic flags_rd,
  output logic cal_we,
  output logic [7:0] cal_wdata
);
  // Idle values at time zero
  initial begin
    {ctrl_we, halt_we, halt_wdata, fail_clr, flags_rd, cal_we} = 6'h00;
    ctrl_wdata = '0;
    cal_wdata = 8'h00;
  end
  // One-cycle control write
  task automatic wr_ctrl(input rsc_pkg::rsc_ctrl_t v);
    @(negedge core_clk) ctrl_we = 1'b1;
    ctrl_wdata = v;
    @(negedge core_clk) ctrl_we = 1'b0;
  endtask
  // Halt bit write
  task automatic wr_halt(input logic v);
    @(negedge core_clk) halt_we = 1'b1;
    halt_wdata = v;
    @(negedge core_clk) halt_we = 1'b0;
  endtask
  // Restart: halt high then straight back low
  task automatic restart();
    wr_halt(1'b1);
    wr_halt(1'b0);
  endtask
  // Clear fail flag only after the oscillator has run a while
  task automatic clr_fail(input int settle);
    repeat (settle) @(negedge core_clk);
    fail_clr = 1'b1;
    @(negedge core_clk) fail_clr = 1'b0;
  endtask
  // Flags read strobe
  task automatic rd_flags();
    @(negedge core_clk) flags_rd = 1'b1;
    @(negedge core_clk) flags_rd = 1'b0;
  endtask
  // Calibration write
  task automatic wr_cal(input logic [7:0] v);
    @(negedge core_clk) cal_we = 1'b1;
    cal_wdata = v;
    @(negedge core_clk) cal_we = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- sim/rsc_core_tb.sv
// Purpose: Self-checking bench for the status and output control block
// Assumes: Shortened prescaler, battery and calibration counts
// Notes: Inputs change on the falling edge
`timescale 1ns/1ns
`default_nettype none
module rsc_core_tb;
  localparam logic [7:0] FCAL = 8'hC3; // Arbitrary trim value
  logic core_clk, rst_n, initial_power, main_power_ok, osc_stopped, batt_below_thr;
  logic year_rollover;
  logic [6:0] year_units;
  logic ctrl_we, halt_we, halt_wdata, fail_clr, flags_rd, cal_we;
  logic [7:0] cal_wdata, cal_reg;
  rsc_pkg::rsc_ctrl_t ctrl_wdata, ctrl_q;
  logic sq_wave_pin, mp_pin_oe, batt_low_flag, osc_fail_flag, century_bit_lo;
  logic century_bit_hi, leap_year, cal_busy, osc_halt_bit, freq_test_en;
  logic countdown_en, stamp_hold_bit;
  int mismatches = 0;
  int total_checks = 0;
  // Host model drives all register strobes
  rsc_host rsc_host_i (.core_clk(core_clk), .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata),
    .halt_we(halt_we), .halt_wdata(halt_wdata), .fail_clr(fail_clr), .flags_rd(flags_rd),
    .cal_we(cal_we), .cal_wdata(cal_wdata));
  // Block under test with short counts
  rsc_core #(.OSC_DIV(4), .BATT_TICKS(20), .CAL_CYCLES(10), .FACTORY_CAL(FCAL)) rsc_core_i (
    .core_clk(core_clk), .rst_n(rst_n), .initial_power(initial_power),
    .main_power_ok(main_power_ok), .osc_stopped(osc_stopped), .batt_below_thr(batt_below_thr),
    .ctrl_we(ctrl_we), .ctrl_wdata(ctrl_wdata), .halt_we(halt_we), .halt_wdata(halt_wdata),
    .fail_clr(fail_clr), .flags_rd(flags_rd), .cal_we(cal_we), .cal_wdata(cal_wdata),
    .year_rollover(year_rollover), .year_units(year_units), .sq_wave_pin(sq_wave_pin),
    .mp_pin_oe(mp_pin_oe), .batt_low_flag(batt_low_flag), .osc_fail_flag(osc_fail_flag),
    .century_bit_lo(century_bit_lo), .century_bit_hi(century_bit_hi), .leap_year(leap_year),
    .cal_reg(cal_reg), .cal_busy(cal_busy), .ctrl_q(ctrl_q), .osc_halt_bit(osc_halt_bit),
    .freq_test_en(freq_test_en), .countdown_en(countdown_en),
    .stamp_hold_bit(stamp_hold_bit));
  // 125 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  // Compare and count
  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
    total_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Verdict and end of run
  task automatic wrap_up();
    if (mismatches == 0 && total_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Power-up with reset held 8 cycles
  task automatic power_up(input logic first);
    @(negedge core_clk) rst_n = 1'b0;
    initial_power = first;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
  endtask
  // Drive the supply and battery comparator levels together
  task automatic set_supply(input logic ok, input logic low);
    main_power_ok = ok;
    batt_below_thr = low;
  endtask
  // Build a control word
  function automatic rsc_pkg::rsc_ctrl_t mk(input logic [3:0] f, input logic sq,
      input logic o, input logic ie, input logic cl);
    return '{f, sq, o, ie, 1'b0, 1'b0, cl};
  endfunction
  // Count square-wave rising edges over 128 cycles
  task automatic rises(output int n);
    logic p;
    n = 0;
    @(negedge core_clk);
    p = sq_wave_pin;
    repeat (128) @(negedge core_clk) begin
      if (sq_wave_pin === 1'b1 && p === 1'b0) n++;
      p = sq_wave_pin;
    end
  endtask
  // Power-on defaults after the initial power-up
  task automatic t_defaults();
    check(ctrl_q.sq_freq_sel, 8'h01, "freq default");
    check({ctrl_q.sq_pin_en, ctrl_q.out_level, osc_fail_flag, stamp_hold_bit}, 8'h0F, "set");
    check({osc_halt_bit, freq_test_en, countdown_en, century_bit_hi, century_bit_lo}, 8'h00, "clr");
    check({ctrl_q.osc_fail_irq_en, ctrl_q.cal_lock}, 8'h00, "clr2");
    check({ctrl_q.alarm1_irq_en, ctrl_q.dog_active}, 8'h00, "clr3");
    check(cal_reg, 8'h00, "cal clr");
  endtask
  // Square wave code, enable and supply
  task automatic t_square();
    int n;
    rises(n);
    check(n, 32, "code 1");
    rsc_host_i.wr_ctrl(mk(4'h2, 1'b1, 1'b1, 1'b0, 1'b0));
    rises(n);
    check(n, 8, "code 2");
    rsc_host_i.wr_ctrl(mk(4'h3, 1'b1, 1'b1, 1'b0, 1'b0));
    rises(n);
    check(n, 4, "code 3");
    set_supply(1'b0, 1'b0);
    rises(n);
    check(n, 0, "supply low");
    set_supply(1'b1, 1'b0);
    rsc_host_i.wr_ctrl(mk(4'h3, 1'b0, 1'b1, 1'b0, 1'b0));
    rises(n);
    check(n, 0, "disabled");
    rsc_host_i.wr_ctrl(mk(4'h0, 1'b1, 1'b1, 1'b0, 1'b0));
    rises(n);
    check(n, 0, "code 0");
  endtask
  // Output level and fail flag interrupt
  task automatic t_pin_fail();
    rsc_host_i.wr_ctrl(mk(4'h0, 1'b0, 1'b0, 1'b0, 1'b0));
    @(negedge core_clk) check(mp_pin_oe, 1, "level low");
    rsc_host_i.wr_ctrl(mk(4'h0, 1'b0, 1'b1, 1'b1, 1'b0));
    @(negedge core_clk) check(mp_pin_oe, 1, "irq on");
    rsc_host_i.rd_flags();
    @(negedge core_clk) check({osc_fail_flag, mp_pin_oe}, 3, "read keeps");
    rsc_host_i.clr_fail(20);
    @(negedge core_clk) check({osc_fail_flag, mp_pin_oe}, 0, "cleared");
    rsc_host_i.restart();
    @(negedge core_clk) check({osc_fail_flag, osc_halt_bit}, 2, "halt set");
    rsc_host_i.clr_fail(2);
    osc_stopped = 1'b1;
    repeat (2) @(negedge core_clk);
    osc_stopped = 1'b0;
    repeat (20) @(negedge core_clk);
    check({osc_fail_flag, mp_pin_oe}, 3, "stop sets");
    rsc_host_i.wr_ctrl(mk(4'h0, 1'b0, 1'b1, 1'b0, 1'b0));
    @(negedge core_clk) check({osc_fail_flag, mp_pin_oe}, 2, "irq off");
    rsc_host_i.wr_ctrl('{4'h0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0});
    @(negedge core_clk) check(mp_pin_oe, 0, "alarm owns pin");
    rsc_host_i.wr_ctrl('{4'h0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0});
    @(negedge core_clk) check(mp_pin_oe, 0, "dog owns pin");
  endtask
  // Battery checks
  task automatic t_battery();
    check(batt_low_flag, 1, "low at power-up");
    set_supply(1'b1, 1'b0);
    repeat (40) @(negedge core_clk);
    check(batt_low_flag, 1, "holds");
    repeat (160) @(negedge core_clk);
    check(batt_low_flag, 0, "passes");
    set_supply(1'b0, 1'b1);
    repeat (200) @(negedge core_clk);
    check(batt_low_flag, 0, "backup");
    set_supply(1'b1, 1'b1);
    repeat (200) @(negedge core_clk);
    check(batt_low_flag, 1, "interval");
    set_supply(1'b1, 1'b0);
  endtask
  // Century counting and leap years
  task automatic t_century();
    logic [1:0] e;
    for (int i = 1; i <= 4; i++) begin
      @(negedge core_clk) year_rollover = 1'b1;
      @(negedge core_clk) year_rollover = 1'b0;
      e = 2'(i);
      @(negedge core_clk) check({century_bit_hi, century_bit_lo}, e, "century");
      check(leap_year, e == 2'b00, "year 00");
    end
    for (int y = 3; y <= 4; y++) begin
      year_units = 7'(y);
      repeat (2) @(negedge core_clk) check(leap_year, y == 4, "leap by four");
    end
  endtask
  // Calibration register
  task automatic t_cal();
    int n;
    rsc_host_i.wr_cal(8'h5A);
    @(negedge core_clk) check(cal_reg, 8'h5A, "rw");
    rsc_host_i.wr_ctrl(mk(4'h0, 1'b0, 1'b1, 1'b0, 1'b1));
    n = 0;
    while (cal_busy !== 1'b1 && n < 5) @(negedge core_clk) n++;
    n = 0;
    while (cal_busy === 1'b1 && n < 50) @(negedge core_clk) n++;
    check(n, 10, "copy time");
    check(cal_reg, FCAL, "factory");
    rsc_host_i.wr_cal(8'h11);
    @(negedge core_clk) check(cal_reg, FCAL, "read only");
  endtask
  // Main sequence
  initial begin
    {rst_n, osc_stopped, year_rollover} = 3'h0;
    initial_power = 1'b1;
    set_supply(1'b1, 1'b1);
    year_units = 7'h00;
    power_up(1'b1);
    t_defaults();
    t_battery();
    t_square();
    t_pin_fail();
    t_century();
    t_cal();
    rsc_host_i.wr_ctrl('{4'h5, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b1});
    power_up(1'b0);
    check({freq_test_en, countdown_en, stamp_hold_bit}, 1, "later power-up");
    check({ctrl_q.sq_freq_sel, ctrl_q.sq_pin_en, ctrl_q.out_level}, 8'h17, "kept");
    check({ctrl_q.dog_active, ctrl_q.cal_lock}, 8'h01, "dog cleared");
    check(cal_reg, FCAL, "cal kept");
    wrap_up();
  end
  // Watchdog on the whole run
  initial begin
    #400000;
    mismatches++;
    wrap_up();
  end
endmodule
`default_nettype wire
